// ---- inc/hesu_pkg.sv ----
package hesu_pkg;

  // Register byte offsets, low address byte only
  localparam logic [7:0] ADDR_BUF_OFS  = 8'h00;
  localparam logic [7:0] SWAP_STAT_OFS = 8'h04;
  localparam logic [7:0] BLK_PTR_OFS   = 8'h08;

  // Control field of the first address buffer word
  localparam int CTL_LO = 8;
  localparam int CTL_HI = 11;

  // Positions inside the four swap enables
  localparam int SW_CMD_BYTE = 0;
  localparam int SW_CMD_WORD = 1;
  localparam int SW_DAT_BYTE = 2;
  localparam int SW_DAT_WORD = 3;

  // Status register layout
  localparam int STAT_SEQ_BIT = 4;
  localparam int STAT_BLK_BIT = 5;

  // Reset values
  localparam logic [3:0]  SWAP_RST = 4'h0;
  localparam logic [31:0] PTR_RST  = 32'h0000_0000;

  // Parameter block double-word indexes
  localparam logic [2:0] BLK_W_ID   = 3'h0;
  localparam logic [2:0] BLK_W_TGT  = 3'h1;
  localparam logic [2:0] BLK_W_ADDR = 3'h2;
  localparam logic [2:0] BLK_W_CNT  = 3'h3;
  localparam logic [2:0] BLK_W_CDB0 = 3'h4;
  localparam logic [2:0] BLK_W_CDB1 = 3'h5;
  localparam logic [2:0] BLK_W_LAST = 3'h6;
  localparam logic [2:0] BLK_W_SAT  = 3'h7;

  // Byte swap within halves, word swap of halves
  // Both together reverse all four bytes
  function automatic logic [31:0] swap_dword(input logic [31:0] d,
                                             input logic        bsw,
                                             input logic        wsw);
    logic [31:0] t;
    t = bsw ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
    return wsw ? {t[15:0], t[31:16]} : t;
  endfunction

  // Byte at offset n of a big-endian double-word
  function automatic logic [7:0] byte_lane(input logic [31:0] d,
                                           input logic [1:0]  n);
    logic [7:0] b;
    case (n)
      2'h0:    b = d[31:24];
      2'h1:    b = d[23:16];
      2'h2:    b = d[15:8];
      default: b = d[7:0];
    endcase
    return b;
  endfunction

endpackage

// ---- inc/hesu_lane_if.sv ----
`timescale 1ns/1ps
interface hesu_lane_if;
  logic        byte_sw;
  logic        word_sw;
  logic        in_valid;
  logic        in_ready;
  logic [31:0] in_data;
  logic        out_valid;
  logic        out_ready;
  logic [31:0] out_data;

  modport lane (input  byte_sw, word_sw, in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport ctrl (output byte_sw, word_sw, in_valid, in_data, out_ready,
                input  in_ready, out_valid, out_data);
endinterface

// ---- logic/hesu_swap_lane.sv ----
`timescale 1ns/1ps
module hesu_swap_lane (
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // Word lane
  hesu_lane_if.lane  lane
);

  logic        vld_r;
  logic        vld_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic        fire;

  assign lane.in_ready  = !vld_r || lane.out_ready;
  assign fire           = lane.in_valid && lane.in_ready;
  assign lane.out_valid = vld_r;
  assign lane.out_data  = dat_r;

  always_comb begin
    vld_nxt = vld_r;
    dat_nxt = dat_r;
    if (fire) begin
      vld_nxt = 1'b1;
      dat_nxt = hesu_pkg::swap_dword(lane.in_data, lane.byte_sw, lane.word_sw);
    end else if (lane.out_ready) begin
      vld_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      vld_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      vld_r <= vld_nxt;
      dat_r <= dat_nxt;
    end
  end

  a_plain_order: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fire && !lane.byte_sw && !lane.word_sw |=> lane.out_data == $past(lane.in_data))
    else $error("unswapped word altered");

  a_full_reverse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fire && lane.byte_sw && lane.word_sw |=>
      lane.out_data == {$past(lane.in_data[7:0]), $past(lane.in_data[15:8]),
                        $past(lane.in_data[23:16]), $past(lane.in_data[31:24])})
    else $error("bytes not fully reversed");

  a_byte_halves: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fire && lane.byte_sw && !lane.word_sw |=>
      lane.out_data == {$past(lane.in_data[23:16]), $past(lane.in_data[31:24]),
                        $past(lane.in_data[7:0]), $past(lane.in_data[15:8])})
    else $error("byte swap wrong");

  a_word_halves: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fire && !lane.byte_sw && lane.word_sw |=>
      lane.out_data == {$past(lane.in_data[15:0]), $past(lane.in_data[31:16])})
    else $error("word swap wrong");

  a_no_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fire |=> lane.out_valid)
    else $error("swap added latency");

  a_hold_stall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    lane.out_valid && !lane.out_ready |=> lane.out_valid && $stable(lane.out_data))
    else $error("output lost under stall");

endmodule

// ---- logic/hesu_top.sv ----
`timescale 1ns/1ps
module hesu_top (
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_N,
  // AHB-Lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // Command structure lane
  input  wire logic        I_CMD_VALID,
  input  wire logic [31:0] I_CMD_DATA,
  output logic             O_CMD_READY,
  output logic             O_CMD_VALID,
  output logic      [31:0] O_CMD_DATA,
  input  wire logic        I_CMD_READY,
  // Transfer data lane
  input  wire logic        I_DAT_VALID,
  input  wire logic [31:0] I_DAT_DATA,
  output logic             O_DAT_READY,
  output logic             O_DAT_VALID,
  output logic      [31:0] O_DAT_DATA,
  input  wire logic        I_DAT_READY,
  // Parameter block decode
  input  wire logic        I_BLK_RESTART,
  output logic      [31:0] O_BLK_PTR,
  output logic             O_BLK_GO,
  output logic             O_BLK_VALID,
  output logic      [31:0] O_BLK_CMD_ID,
  output logic      [7:0]  O_BLK_FLAGS2,
  output logic      [7:0]  O_BLK_FLAGS1,
  output logic      [7:0]  O_BLK_ADDR_MOD,
  output logic      [7:0]  O_BLK_TARGET,
  output logic      [31:0] O_BLK_MEM_ADDR,
  output logic      [31:0] O_BLK_XFER_CNT,
  output logic      [95:0] O_BLK_CDB
);

  typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD_WAIT, BUS_RD_DONE} hesu_bus_e;

  hesu_bus_e   bus_r;
  hesu_bus_e   bus_nxt;
  logic [7:0]  addr_r;
  logic [7:0]  addr_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [31:0] rd_val;
  logic        ap_ok;

  logic [3:0]  swap_r;
  logic [3:0]  swap_nxt;
  logic        seq_r;
  logic        seq_nxt;
  logic [31:0] ptr_r;
  logic [31:0] ptr_nxt;
  logic        go_r;
  logic        go_nxt;
  logic        buf_wr;

  logic [2:0]  idx_r;
  logic [2:0]  idx_nxt;
  logic [2:0]  base;
  logic        cmd_fire;
  logic        bv_r;
  logic        bv_nxt;
  logic [31:0] id_r;
  logic [31:0] id_nxt;
  logic [31:0] w1_r;
  logic [31:0] w1_nxt;
  logic [31:0] ma_r;
  logic [31:0] ma_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [95:0] cdb_r;
  logic [95:0] cdb_nxt;

  hesu_lane_if cmd_if ();
  hesu_lane_if dat_if ();

  // Bus slave: writes take no wait, reads one
  assign ap_ok       = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign O_HREADYOUT = bus_r != BUS_RD_WAIT;
  assign O_HRESP     = 1'b0;
  assign O_HRDATA    = rdat_r;

  always_comb begin
    bus_nxt  = bus_r;
    addr_nxt = addr_r;
    rdat_nxt = rdat_r;
    case (addr_r)
      hesu_pkg::SWAP_STAT_OFS: begin
        rd_val = 32'h0000_0000;
        rd_val[3:0] = swap_r;
        rd_val[hesu_pkg::STAT_SEQ_BIT] = seq_r;
        rd_val[hesu_pkg::STAT_BLK_BIT] = bv_r;
      end
      hesu_pkg::BLK_PTR_OFS: rd_val = ptr_r;
      default:               rd_val = 32'h0000_0000;
    endcase
    case (bus_r)
      BUS_RD_WAIT: begin
        bus_nxt  = BUS_RD_DONE;
        rdat_nxt = rd_val;
      end
      default: begin
        bus_nxt = BUS_IDLE;
        if (ap_ok) begin
          addr_nxt = I_HADDR[7:0];
          bus_nxt  = I_HWRITE ? BUS_WR : BUS_RD_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      bus_r  <= BUS_IDLE;
      addr_r <= 8'h00;
      rdat_r <= 32'h0000_0000;
    end else begin
      bus_r  <= bus_nxt;
      addr_r <= addr_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Address buffer port: control word, then block pointer
  assign buf_wr    = (bus_r == BUS_WR) && (addr_r == hesu_pkg::ADDR_BUF_OFS);
  assign O_BLK_PTR = ptr_r;
  assign O_BLK_GO  = go_r;

  always_comb begin
    swap_nxt = swap_r;
    seq_nxt  = seq_r;
    ptr_nxt  = ptr_r;
    go_nxt   = 1'b0;
    if (buf_wr) begin
      if (!seq_r) begin
        swap_nxt = I_HWDATA[hesu_pkg::CTL_HI:hesu_pkg::CTL_LO];
        seq_nxt  = 1'b1;
      end else begin
        ptr_nxt = I_HWDATA;
        seq_nxt = 1'b0;
        go_nxt  = 1'b1;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      swap_r <= hesu_pkg::SWAP_RST;
      seq_r  <= 1'b0;
      ptr_r  <= hesu_pkg::PTR_RST;
      go_r   <= 1'b0;
    end else begin
      swap_r <= swap_nxt;
      seq_r  <= seq_nxt;
      ptr_r  <= ptr_nxt;
      go_r   <= go_nxt;
    end
  end

  assign cmd_if.byte_sw   = swap_r[hesu_pkg::SW_CMD_BYTE];
  assign cmd_if.word_sw   = swap_r[hesu_pkg::SW_CMD_WORD];
  assign dat_if.byte_sw   = swap_r[hesu_pkg::SW_DAT_BYTE];
  assign dat_if.word_sw   = swap_r[hesu_pkg::SW_DAT_WORD];
  assign cmd_if.in_valid  = I_CMD_VALID;
  assign cmd_if.in_data   = I_CMD_DATA;
  assign cmd_if.out_ready = I_CMD_READY;
  assign dat_if.in_valid  = I_DAT_VALID;
  assign dat_if.in_data   = I_DAT_DATA;
  assign dat_if.out_ready = I_DAT_READY;
  assign O_CMD_READY      = cmd_if.in_ready;
  assign O_CMD_VALID      = cmd_if.out_valid;
  assign O_CMD_DATA       = cmd_if.out_data;
  assign O_DAT_READY      = dat_if.in_ready;
  assign O_DAT_VALID      = dat_if.out_valid;
  assign O_DAT_DATA       = dat_if.out_data;

  hesu_swap_lane u_cmd_lane (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .lane    (cmd_if)
  );

  hesu_swap_lane u_dat_lane (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .lane    (dat_if)
  );

  // Parameter block decode from big-endian words
  assign cmd_fire       = cmd_if.out_valid && I_CMD_READY;
  assign base           = I_BLK_RESTART ? hesu_pkg::BLK_W_ID : idx_r;
  assign O_BLK_VALID    = bv_r;
  assign O_BLK_CMD_ID   = id_r;
  assign O_BLK_FLAGS2   = hesu_pkg::byte_lane(w1_r, 2'h0);
  assign O_BLK_FLAGS1   = hesu_pkg::byte_lane(w1_r, 2'h1);
  assign O_BLK_ADDR_MOD = hesu_pkg::byte_lane(w1_r, 2'h2);
  assign O_BLK_TARGET   = hesu_pkg::byte_lane(w1_r, 2'h3);
  assign O_BLK_MEM_ADDR = ma_r;
  assign O_BLK_XFER_CNT = cnt_r;
  assign O_BLK_CDB      = cdb_r;

  always_comb begin
    idx_nxt = base;
    bv_nxt  = I_BLK_RESTART ? 1'b0 : bv_r;
    id_nxt  = id_r;
    w1_nxt  = w1_r;
    ma_nxt  = ma_r;
    cnt_nxt = cnt_r;
    cdb_nxt = cdb_r;
    if (cmd_fire) begin
      if (base != hesu_pkg::BLK_W_SAT) begin
        idx_nxt = base + 3'h1;
      end
      case (base)
        hesu_pkg::BLK_W_ID:   id_nxt = O_CMD_DATA;
        hesu_pkg::BLK_W_TGT:  w1_nxt = O_CMD_DATA;
        // Lane 0 holds the most significant byte
        hesu_pkg::BLK_W_ADDR: ma_nxt = O_CMD_DATA;
        hesu_pkg::BLK_W_CNT:  cnt_nxt = O_CMD_DATA;
        hesu_pkg::BLK_W_CDB0: cdb_nxt[95:64] = O_CMD_DATA;
        hesu_pkg::BLK_W_CDB1: cdb_nxt[63:32] = O_CMD_DATA;
        hesu_pkg::BLK_W_LAST: begin
          cdb_nxt[31:0] = O_CMD_DATA;
          bv_nxt        = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      idx_r <= hesu_pkg::BLK_W_ID;
      bv_r  <= 1'b0;
      id_r  <= 32'h0000_0000;
      w1_r  <= 32'h0000_0000;
      ma_r  <= 32'h0000_0000;
      cnt_r <= 32'h0000_0000;
      cdb_r <= 96'h0;
    end else begin
      idx_r <= idx_nxt;
      bv_r  <= bv_nxt;
      id_r  <= id_nxt;
      w1_r  <= w1_nxt;
      ma_r  <= ma_nxt;
      cnt_r <= cnt_nxt;
      cdb_r <= cdb_nxt;
    end
  end

  a_first_word_latch: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    buf_wr && !seq_r |=> swap_r == $past(I_HWDATA[hesu_pkg::CTL_HI:hesu_pkg::CTL_LO]) && seq_r)
    else $error("control field not latched");

  a_second_word_ptr: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    buf_wr && seq_r |=> O_BLK_GO && $stable(swap_r) ##1 !O_BLK_GO)
    else $error("second word changed enables");

  a_status_enables: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    bus_r == BUS_RD_DONE && addr_r == hesu_pkg::SWAP_STAT_OFS |->
      O_HRDATA[3:0] == swap_r)
    else $error("status does not show enables");

  a_write_no_wait: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    ap_ok && I_HWRITE |=> O_HREADYOUT)
    else $error("write stalled");

  a_read_one_wait: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    ap_ok && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
    else $error("read wait wrong");

  a_target_lane: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    cmd_fire && base == hesu_pkg::BLK_W_TGT |=>
      O_BLK_TARGET == $past(O_CMD_DATA[7:0]) && O_BLK_FLAGS2 == $past(O_CMD_DATA[31:24]))
    else $error("second word fields misplaced");

  a_cdb_first: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    cmd_fire && base == hesu_pkg::BLK_W_CDB0 |=> O_BLK_CDB[95:88] == $past(O_CMD_DATA[31:24]))
    else $error("command byte 0 misplaced");

  a_msb_low_addr: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    cmd_fire && base == hesu_pkg::BLK_W_ADDR |=> O_BLK_MEM_ADDR[31:24] == $past(O_CMD_DATA[31:24]))
    else $error("address byte order wrong");

  a_block_done: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    cmd_fire && base == hesu_pkg::BLK_W_LAST |=> O_BLK_VALID)
    else $error("block not marked complete");

endmodule

// ---- testbench/hesu_sink_model.sv ----
`timescale 1ns/1ps
module hesu_sink_model (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Stall control and lane handshake
  input  wire logic i_slow,
  output logic      o_ready
);
  logic [3:0] cnt_r;

  // Free-running phase counter for the stall pattern
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Slow memory refuses three cycles in every eight
  assign o_ready = !i_slow || (cnt_r[2:0] > 3'h2);
endmodule

// ---- testbench/host_endian_swap_unit_tb.sv ----
`timescale 1ns/1ps
module host_endian_swap_unit_tb;
  logic        clk, rst_n, hsel, hwrite, hready, hresp, restart, slow;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, ptr, cd, dd, c_od, d_od;
  logic        cv, c_rdy, c_ov, c_sr, dv, d_rdy, d_ov, d_sr, pend0, pend1, b_vld;
  logic [31:0] eq0[$], eq1[$], src[8];
  logic [31:0] b_id, b_ma, b_xc, b_ptr;
  logic        b_go;
  logic [7:0]  b_f2, b_f1, b_am, b_tg;
  logic [95:0] b_cdb;
  logic [3:0]  en;
  int          n_mismatch, tests_run, seed;
  logic [31:0] blk[7] = '{32'h0403_0201, 32'h0186_3e02, 32'h005a_9320, 32'h0001_0280,
                          32'h2a40_0008, 32'hf4e9_0002, 32'h0500_0000};

  hesu_top u_dut (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_CMD_VALID(cv), .I_CMD_DATA(cd), .O_CMD_READY(c_rdy), .O_CMD_VALID(c_ov),
    .O_CMD_DATA(c_od), .I_CMD_READY(c_sr),
    .I_DAT_VALID(dv), .I_DAT_DATA(dd), .O_DAT_READY(d_rdy), .O_DAT_VALID(d_ov),
    .O_DAT_DATA(d_od), .I_DAT_READY(d_sr),
    .I_BLK_RESTART(restart), .O_BLK_PTR(b_ptr), .O_BLK_GO(b_go), .O_BLK_VALID(b_vld),
    .O_BLK_CMD_ID(b_id), .O_BLK_FLAGS2(b_f2), .O_BLK_FLAGS1(b_f1), .O_BLK_ADDR_MOD(b_am),
    .O_BLK_TARGET(b_tg), .O_BLK_MEM_ADDR(b_ma), .O_BLK_XFER_CNT(b_xc), .O_BLK_CDB(b_cdb)
  );

  hesu_sink_model u_cmd_mem (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .o_ready(c_sr));
  hesu_sink_model u_dat_mem (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .o_ready(d_sr));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] swp(input logic [31:0] d, input logic b, input logic w);
    logic [31:0] t;
    t = b ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
    return w ? {t[15:0], t[31:16]} : t;
  endfunction

  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Ready is judged at the falling edge, before the next rising edge moves it
  task automatic wait_rdy();
    logic ok;
    int   n;
    n = 0;
    do begin
      @(negedge clk);
      ok = hready;
      rd = hrdata;
      n++;
      @(posedge clk);
    end while (ok !== 1'b1 && n < 100);
    chk("hready", ok, 1'b1);
    chk("hresp", hresp, 1'b0);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask

  // Back-to-back words from src, valid held high across the burst
  task automatic burst(input int ln, input int n);
    if (ln == 0) cv <= 1'b1; else dv <= 1'b1;
    for (int k = 0; k < n; k++) begin
      if (ln == 0) cd <= src[k]; else dd <= src[k];
      do @(negedge clk); while ((ln == 0 ? c_rdy : d_rdy) !== 1'b1);
      @(posedge clk);
    end
    if (ln == 0) cv <= 1'b0; else dv <= 1'b0;
  endtask

  task automatic drain();
    repeat (200) if (eq0.size() + eq1.size() != 0) @(posedge clk);
    chk("lanes drained", 96'(eq0.size() + eq1.size()), 96'h0);
  endtask

  task automatic blk_run(input logic [3:0] e, input logic rev);
    en = e;
    ahb(1'b1, 8'h00, {20'h0, e, 8'h00});
    ahb(1'b1, 8'h00, 32'h0008_9ff4);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    for (int k = 0; k < 7; k++)
      src[k] = rev ? {blk[k][7:0], blk[k][15:8], blk[k][23:16], blk[k][31:24]} : blk[k];
    @(negedge clk);
    chk("restart clears valid", b_vld, 1'b0);
    @(posedge clk);
    burst(0, 7);
    drain();
    @(negedge clk);
    chk("command id", b_id, 32'h0403_0201);
    chk("target word lanes", {b_f2, b_f1, b_am, b_tg}, 32'h0186_3e02);
    chk("memory address", b_ma, 32'h005a_9320);
    chk("transfer count", b_xc, 32'h0001_0280);
    chk("command bytes", b_cdb, 96'h2a40_0008_f4e9_0002_0500_0000);
    chk("block valid", b_vld, 1'b1);
    @(posedge clk);
    $display("Test parameter block mode %h done", e);
  endtask

  // Scoreboard: expected words are queued at acceptance with the enables then in force
  always @(negedge clk) begin
    if (rst_n) begin
      if (pend0) chk("cmd latency", c_ov, 1'b1);
      if (pend1) chk("dat latency", d_ov, 1'b1);
      if (c_ov && c_sr) chk("cmd word", c_od, eq0.size() ? eq0.pop_front() : 'x);
      if (d_ov && d_sr) chk("dat word", d_od, eq1.size() ? eq1.pop_front() : 'x);
      pend0 = cv && c_rdy && (!c_ov || c_sr);
      pend1 = dv && d_rdy && (!d_ov || d_sr);
      if (cv && c_rdy) eq0.push_back(swp(cd, en[0], en[1]));
      if (dv && d_rdy) eq1.push_back(swp(dd, en[2], en[3]));
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    seed = 76;
    n_mismatch = 0;
    tests_run = 0;
    {rst_n, hsel, hwrite, restart, slow, cv, dv, pend0, pend1} = '0;
    {htrans, haddr, hwdata, cd, dd, en} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    ahb(1'b0, 8'h04, 32'h0);
    chk("status after reset", rd, 32'h0);
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped read", rd, 32'h0);
    $display("Test reset done");
    for (int m = 0; m < 16; m++) begin
      en = m[3:0];
      ptr = $random(seed);
      ahb(1'b1, 8'h00, {ptr[31:12], en, ptr[7:0]});
      @(negedge clk);
      chk("no go on first word", b_go, 1'b0);
      @(posedge clk);
      ahb(1'b0, 8'h04, 32'h0);
      chk("second word pending", rd[4:0], {1'b1, en});
      ahb(1'b1, 8'h00, ptr);
      @(negedge clk);
      chk("go pulse", b_go, 1'b1);
      chk("pointer out", b_ptr, ptr);
      @(posedge clk);
      ahb(1'b0, 8'h04, 32'h0);
      chk("status enables", rd[4:0], {1'b0, en});
      ahb(1'b0, 8'h08, 32'h0);
      chk("block pointer", rd, ptr);
      ahb(1'b0, 8'h00, 32'h0);
      chk("port reads zero", rd, 32'h0);
      slow <= m[0];
      for (int k = 0; k < 8; k++) src[k] = $random(seed);
      src[0] = 32'h0123_4567;
      src[7] = 32'hffff_0000;
      burst(0, 8);
      burst(1, 8);
      drain();
      $display("Test swap mode %h done", en);
    end
    blk_run(4'h0, 1'b0);
    blk_run(4'h3, 1'b1);
    test_done();
  end
endmodule
